// >>> hdl/rsc_pkg.sv
package rsc_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned RATE_DEF_SPS  = 1024;
  localparam int unsigned RATE_SLOW_SPS = 8;
  localparam int unsigned RATE_MAX_SPS  = 8192;
  localparam int unsigned UPD_DELAY_NS  = 1000;
  localparam int unsigned CLK_NS        = 1_000_000_000 / CLK_HZ;
  // Longest time rounds down, never below one cycle.
  localparam int unsigned UPD_DELAY_CYC = (UPD_DELAY_NS / CLK_NS) < 1 ? 1 : UPD_DELAY_NS / CLK_NS;
  // Active (sampling) part of every cycle, the whole cycle at the top rate.
  localparam int unsigned ACTIVE_CYC    = CLK_HZ / RATE_MAX_SPS;

  // ****************************************************************
  // APB register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_CONTROL  = 8'h00;
  localparam logic [7:0] ADDR_ACTIVE   = 8'h04;
  localparam logic [7:0] ADDR_COMMAND  = 8'h08;
  localparam logic [7:0] ADDR_STATUS   = 8'h0c;
  localparam logic [7:0] ADDR_BUS      = 8'h10;
  localparam logic [7:0] ADDR_SHUNT    = 8'h14;
  localparam logic [7:0] ADDR_POWER    = 8'h18;
  localparam logic [7:0] ADDR_ACC_LO   = 8'h1c;
  localparam logic [7:0] ADDR_ACC_HI   = 8'h20;
  localparam logic [7:0] ADDR_COUNT    = 8'h24;

  // Control word fields.
  localparam int unsigned CTL_RATE_LSB = 0;
  localparam int unsigned CTL_AUTO_LSB = 4;
  localparam int unsigned CTL_P0_LSB   = 8;
  localparam int unsigned CTL_P1_LSB   = 10;
  localparam logic [15:0] CTL_RESET    = 16'h0000;
  localparam logic [1:0]  PIN_SLOW     = 2'h3;

  // Command codes written to ADDR_COMMAND.
  localparam logic [1:0] CMD_REFRESH   = 2'h1;
  localparam logic [1:0] CMD_REFRESH_G = 2'h2;
  localparam logic [1:0] CMD_REFRESH_V = 2'h3;

  typedef enum logic [1:0] {PEND_NONE, PEND_CLEAR, PEND_KEEP} rsc_pend_e;

  typedef enum logic [0:0] {PH_ACTIVE, PH_IDLE} rsc_phase_e;

  typedef struct packed {
    logic [15:0] bus_v;
    logic [15:0] shunt_v;
    logic [31:0] power;
  } rsc_sample_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } rsc_apb_req_s;

endpackage

// >>> hdl/rsc_top.sv
module rsc_top
  import rsc_pkg::*;
#(
  parameter int unsigned CLK_FREQ_HZ = CLK_HZ
) (
  input  wire logic              clock_i,
  input  wire logic              arst_n_i,
  input  wire rsc_pkg::rsc_apb_req_s apb_i,
  output logic                   pready_o,
  output logic                   pslverr_o,
  output logic [31:0]            prdata_o,
  input  wire logic              pin0_i,
  input  wire logic              pin1_i,
  input  wire rsc_pkg::rsc_sample_s adc_i,
  output logic                   adc_sample_o,
  output logic                   cycle_done_o
);
  import rsc_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [1:0]  rst_sync;
    logic [1:0]  pin0_sync;
    logic [1:0]  pin1_sync;
    logic [15:0] ctl_written;
    logic [15:0] active_config_copy;
    logic        cfg_arm;
    rsc_pend_e   pend;
    rsc_phase_e  phase;
    logic [22:0] cyc_cnt;
    logic [22:0] cyc_len;
    logic        post_busy;
    logic        post_clear;
    logic [5:0]  post_cnt;
    rsc_sample_s latest;
    logic [55:0] accumulated_power_value;
    logic [31:0] accumulation_count;
    rsc_sample_s snap;
    logic [55:0] snap_acc;
    logic [31:0] snap_cnt;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        adc_sample;
    logic        cycle_done;
  } rsc_state_s;

  // ****************************************************************
  // Working signals
  // ****************************************************************
  // All state sits in one struct, so a single always_ff and two
  // always_comb blocks describe the whole block.
  // The price is that every field resets together. Nothing here needs
  // a separate reset domain, so that is acceptable.
  // Fields that only the bus side reads, such as the snapshots, still
  // live in the same struct to keep the update order in one place.

  rsc_state_s  st_reg;
  rsc_state_s  st_next;
  logic        rst_n;
  logic [1:0]  auto_w;
  logic [1:0]  auto_a;
  logic [3:0]  rate_a;
  logic        slow;
  logic [22:0] len_sel;
  logic        cyc_end;
  logic        wr;
  logic        rd;
  logic [31:0] prod;

  // The asynchronous reset is released through two flip-flops.
  // Without them a release close to a clock edge could leave part of the
  // state in reset and part of it running for one cycle.
  // The rest of the logic holds its reset values while this copy is low.
  assign rst_n = st_reg.rst_sync[1];

  // The active copy decides the running behaviour. The written control
  // word only matters when a refresh arms it, when it differs from the
  // active copy and so holds off auto snapshots, or when the auto field
  // of the two differs and a manual refresh must be let through.
  // Keeping both copies lets software read back what it wrote even
  // while the old settings are still in force.

  // ****************************************************************
  // Rate selection
  // ****************************************************************
  assign auto_w = st_reg.ctl_written[CTL_AUTO_LSB +: 2];
  assign auto_a = st_reg.active_config_copy[CTL_AUTO_LSB +: 2];
  assign rate_a = st_reg.active_config_copy[CTL_RATE_LSB +: 4];

  assign slow = (st_reg.active_config_copy[CTL_P0_LSB +: 2] == PIN_SLOW && st_reg.pin0_sync[1])
             || (st_reg.active_config_copy[CTL_P1_LSB +: 2] == PIN_SLOW && st_reg.pin1_sync[1]);

  always_comb begin
    if (slow) begin
      len_sel = 23'(CLK_FREQ_HZ / RATE_SLOW_SPS);
    end else begin
      case (rate_a)
        4'h1:    len_sel = 23'(CLK_FREQ_HZ / 8192);
        4'h2:    len_sel = 23'(CLK_FREQ_HZ / 4096);
        4'h3:    len_sel = 23'(CLK_FREQ_HZ / 256);
        4'h4:    len_sel = 23'(CLK_FREQ_HZ / 64);
        4'h5:    len_sel = 23'(CLK_FREQ_HZ / RATE_SLOW_SPS);
        default: len_sel = 23'(CLK_FREQ_HZ / RATE_DEF_SPS);
      endcase
    end
  end

  // The cycle length is latched at every cycle end, not taken live.
  // A rate change or a slow pin edge therefore never cuts a cycle short
  // or stretches one that is already running.
  // The counter is wide enough for the slowest rate at the full clock.
  assign cyc_end = (st_reg.cyc_cnt == st_reg.cyc_len - 23'h000001);

  // Bus strobes count once: the ready flag blocks a second write or read
  // in the cycle in which ready is shown.
  assign wr      = apb_i.psel && apb_i.penable && apb_i.pwrite && !st_reg.pready;
  assign rd      = apb_i.psel && apb_i.penable && !apb_i.pwrite && !st_reg.pready;
  assign prod    = 32'(adc_i.bus_v) * 32'(adc_i.shunt_v);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_next            = st_reg;
    st_next.rst_sync   = {st_reg.rst_sync[0], 1'b1};
    st_next.pin0_sync  = {st_reg.pin0_sync[0], pin0_i};
    st_next.pin1_sync  = {st_reg.pin1_sync[0], pin1_i};
    st_next.adc_sample = 1'b0;
    st_next.cycle_done = 1'b0;
    st_next.pready     = 1'b0;
    st_next.pslverr    = 1'b0;

    // The cycle counter is never touched by the bus side. Refresh
    // commands only leave a pending mark that the cycle end consumes,
    // so software traffic cannot shift the sampling grid.
    // The active phase spans the part of a cycle that the top rate
    // needs. At lower rates the rest of the cycle is marked idle, which
    // is where a real converter would save its power.

    if (cyc_end) begin
      st_next.cyc_cnt = '0;
      st_next.phase   = PH_ACTIVE;
      st_next.cyc_len = len_sel;
    end else begin
      st_next.cyc_cnt = st_reg.cyc_cnt + 23'h000001;
      if (st_reg.cyc_cnt == 23'(CLK_FREQ_HZ / RATE_MAX_SPS - 1)) begin
        st_next.phase = PH_IDLE;
      end
    end

    if (st_reg.cyc_cnt == '0) begin
      st_next.adc_sample = 1'b1;
    end
    if (cyc_end) begin
      st_next.latest.bus_v   = adc_i.bus_v;
      st_next.latest.shunt_v = adc_i.shunt_v;
      st_next.latest.power   = prod;
      st_next.accumulated_power_value = st_reg.accumulated_power_value + 56'(prod);
      st_next.accumulation_count      = st_reg.accumulation_count + 32'h00000001;
      st_next.cycle_done = 1'b1;
    end

    // The snapshot waits a fixed time after the cycle end. That time is
    // counted in clocks of the fixed system clock, so it does not scale
    // with the cycle length parameter.
    // A plain refresh clears the accumulator at the snapshot moment.
    // When a new cycle ends on that same edge its sample is kept as the
    // first term of the new sum, so no sample is lost.

    if (st_reg.post_busy) begin
      if (st_reg.post_cnt == 6'(UPD_DELAY_CYC - 1)) begin
        st_next.post_busy = 1'b0;
        st_next.snap     = st_reg.latest;
        st_next.snap_acc = st_reg.accumulated_power_value;
        st_next.snap_cnt = st_reg.accumulation_count;
        if (st_reg.post_clear) begin
          st_next.accumulated_power_value = cyc_end ? 56'(prod) : '0;
          st_next.accumulation_count      = cyc_end ? 32'h00000001 : '0;
        end
      end else begin
        st_next.post_cnt = st_reg.post_cnt + 6'h01;
      end
    end

    // Auto mode wins over a pending manual refresh. A pending mark left
    // from before auto mode was switched on stays pending until the written
    // control word differs from the active copy, which matches the rule that auto overrules the rest.
    // Config is copied one cycle after the refresh was applied, so the
    // snapshot of that refresh still belongs to the old settings.

    if (cyc_end) begin
      if (auto_a != 2'h0 && st_reg.ctl_written == st_reg.active_config_copy) begin
        st_next.post_busy  = 1'b1;
        st_next.post_clear = 1'b0;
        st_next.post_cnt   = '0;
      end else if (st_reg.pend != PEND_NONE) begin
        st_next.post_busy  = 1'b1;
        st_next.post_clear = (st_reg.pend == PEND_CLEAR);
        st_next.post_cnt   = '0;
        st_next.pend       = PEND_NONE;
        st_next.cfg_arm    = 1'b1;
      end
      if (st_reg.cfg_arm) begin
        st_next.active_config_copy = st_reg.ctl_written;
        st_next.cfg_arm            = 1'b0;
      end
    end

    // ****************************************************************
    // APB slave, one wait state
    // ****************************************************************
    if (apb_i.psel && apb_i.penable && !st_reg.pready) begin
      st_next.pready = 1'b1;
    end
    // Only the control word and the command register can be written.
    // Everything else, the active copy included, answers with an error.
    // A command with an unknown code is taken as a write but changes
    // nothing, so a stray value cannot start a snapshot.
    // A newer command replaces the pending one, so only the latest type
    // is applied at the cycle end.

    if (wr) begin
      case (apb_i.paddr)
        ADDR_CONTROL: st_next.ctl_written = apb_i.pwdata[15:0];
        ADDR_COMMAND: begin
          if (auto_a == 2'h0 || auto_w != auto_a) begin
            case (apb_i.pwdata[1:0])
              CMD_REFRESH, CMD_REFRESH_G: st_next.pend = PEND_CLEAR;
              CMD_REFRESH_V: st_next.pend = PEND_KEEP;
              default: st_next.pend = st_reg.pend;
            endcase
          end
        end
        default: st_next.pslverr = 1'b1;
      endcase
    end
    if (rd) begin
      case (apb_i.paddr)
        ADDR_CONTROL: st_next.prdata = {16'h0000, st_reg.ctl_written};
        ADDR_ACTIVE:  st_next.prdata = {16'h0000, st_reg.active_config_copy};
        ADDR_STATUS:  st_next.prdata = {28'h0000000, st_reg.post_busy,
                                        st_reg.phase == PH_IDLE, st_reg.pend};
        ADDR_BUS:     st_next.prdata = {16'h0000, st_reg.snap.bus_v};
        ADDR_SHUNT:   st_next.prdata = {16'h0000, st_reg.snap.shunt_v};
        ADDR_POWER:   st_next.prdata = st_reg.snap.power;
        ADDR_ACC_LO:  st_next.prdata = st_reg.snap_acc[31:0];
        ADDR_ACC_HI:  st_next.prdata = {8'h00, st_reg.snap_acc[55:32]};
        ADDR_COUNT:   st_next.prdata = st_reg.snap_cnt;
        default: begin
          st_next.prdata  = '0;
          st_next.pslverr = 1'b1;
        end
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // The cycle length is the one field whose reset value is not zero.
  // It starts at the default rate so the first cycle after reset already
  // has the documented length.
  // During the synchronous part of the reset the synchroniser keeps
  // shifting, and nothing else moves.

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg <= '0;
      st_reg.cyc_len <= 23'(CLK_FREQ_HZ / RATE_DEF_SPS);
    end else if (!rst_n) begin
      st_reg          <= '0;
      st_reg.rst_sync <= st_next.rst_sync;
      st_reg.cyc_len  <= 23'(CLK_FREQ_HZ / RATE_DEF_SPS);
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Every output is a field of the state register, so none of them
  // carries a combinational path from an input.

  assign pready_o     = st_reg.pready;
  assign pslverr_o    = st_reg.pslverr;
  assign prdata_o     = st_reg.prdata;
  assign adc_sample_o = st_reg.adc_sample;
  assign cycle_done_o = st_reg.cycle_done;

endmodule

// >>> tb/rsc_adc_model.sv
module rsc_adc_model
  import rsc_pkg::*;
(
  input  wire logic            clock_i,
  input  wire logic            sample_i,
  output rsc_pkg::rsc_sample_s adc_o
);
  import rsc_pkg::*;
  // ****************************************************************
  // Converter answer
  // ****************************************************************
  // Each pair steps by one, so a stale or torn capture shows up at once.
  logic [15:0] n = 16'h0001;
  always_ff @(posedge clock_i) begin
    if (sample_i) begin
      n <= n + 16'h0001;
    end
  end
  assign adc_o = '{bus_v: 16'h0100 + n, shunt_v: 16'h0200 + n, power: ~{n, n}};
endmodule

// >>> tb/rsc_top_asserts.sv
module rsc_top_asserts
  import rsc_pkg::*;
#(
  parameter int unsigned CLK_FREQ_HZ = CLK_HZ
) (
  input wire logic                 clock_i,
  input wire logic                 arst_n_i,
  input wire rsc_pkg::rsc_apb_req_s apb_i,
  input wire logic                 pready_o,
  input wire logic                 pslverr_o,
  input wire logic [31:0]          prdata_o,
  input wire logic                 pin0_i,
  input wire logic                 pin1_i,
  input wire rsc_pkg::rsc_sample_s adc_i,
  input wire logic                 adc_sample_o,
  input wire logic                 cycle_done_o
);
  import rsc_pkg::*;
  localparam int unsigned PERIOD      = CLK_FREQ_HZ / RATE_DEF_SPS;
  localparam int unsigned SLOW_PERIOD = CLK_FREQ_HZ / RATE_SLOW_SPS;
  logic [31:0] cnt_reg;
  logic        seen_reg;
  logic        slw_reg;
  logic        smp_reg;
  // The first cycle after reset has no known start, so it is not timed.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_reg  <= 32'h0;
      seen_reg <= 1'b0;
      smp_reg  <= 1'b0;
      slw_reg  <= 1'b0;
    end else begin
      slw_reg  <= pin0_i | pin1_i | (slw_reg & ~cycle_done_o);
      cnt_reg  <= cycle_done_o ? 32'h0 : cnt_reg + 32'h1;
      seen_reg <= seen_reg | cycle_done_o;
      smp_reg  <= adc_sample_o | (smp_reg & ~cycle_done_o);
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  sequence acc_start;
    apb_i.psel && $rose(apb_i.penable);
  endsequence
  sequence one_wait;
    ##1 pready_o ##1 !pready_o;
  endsequence
  AST_ONE_WAIT: assert property (acc_start |-> one_wait)
    else $error("access not answered after one wait state");
  AST_READY_CAUSE: assert property (pready_o |-> $past(apb_i.psel && apb_i.penable))
    else $error("ready without an access");
  AST_ERR_WITH_READY: assert property (pslverr_o |-> pready_o)
    else $error("error outside a ready cycle");
  AST_UNMAPPED: assert property (acc_start and apb_i.paddr > ADDR_COUNT |-> ##1 pslverr_o)
    else $error("unmapped access not refused");
  AST_RO_ACTIVE: assert property (
    acc_start and apb_i.pwrite && apb_i.paddr == ADDR_ACTIVE |-> ##1 pslverr_o)
    else $error("write to active copy not refused");
  AST_SAMPLE_FIRST: assert property (cycle_done_o |-> smp_reg)
    else $error("cycle ended without a sample");
  AST_ONE_SAMPLE: assert property (adc_sample_o && !cycle_done_o |-> !smp_reg)
    else $error("second sample inside one cycle");
  AST_PERIOD: assert property (cycle_done_o && seen_reg |-> cnt_reg == PERIOD - 1 || (slw_reg && cnt_reg == SLOW_PERIOD - 1))
    else $error("cycle length off the default rate");
endmodule

bind rsc_top rsc_top_asserts #(.CLK_FREQ_HZ(CLK_FREQ_HZ)) i_rsc_top_asserts (.clock_i,
  .arst_n_i, .apb_i, .pready_o, .pslverr_o, .prdata_o, .pin0_i, .pin1_i, .adc_i,
  .adc_sample_o, .cycle_done_o);

// >>> tb/test_refresh_snapshot_control.sv
module test_refresh_snapshot_control;
  timeunit 1ns;
  timeprecision 100ps;
  import rsc_pkg::*;
  localparam logic [7:0] AD [4] = '{ADDR_BUS, ADDR_SHUNT, ADDR_POWER, ADDR_COUNT};
  logic         clock_i;
  logic         arst_n_i;
  rsc_apb_req_s req;
  rsc_sample_s  adc;
  logic         rdy, serr, smp, done, err;
  logic         pin0;
  logic [31:0]  prdata, rd;
  logic [31:0]  v [4];
  int           fail_count, n_checks;
  // ****************************************************************
  // Harness
  // ****************************************************************
  rsc_top #(.CLK_FREQ_HZ(409600)) i_rsc_top (.clock_i, .arst_n_i, .apb_i(req),
    .pready_o(rdy), .pslverr_o(serr), .prdata_o(prdata), .pin0_i(pin0), .pin1_i(pin0),
    .adc_i(adc), .adc_sample_o(smp), .cycle_done_o(done));
  rsc_adc_model i_rsc_adc_model (.clock_i, .sample_i(smp), .adc_o(adc));
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clock_i);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock_i);
    req.penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clock_i);
      i++;
    end while (rdy !== 1'b1 && i < 50);
    if (i >= 50) begin
      fail_count++;
      end_sim();
    end
    rd = prdata;
    err = serr;
    req <= '0;
  endtask
  task automatic wait_done(input int n);
    int i;
    repeat (n) begin
      i = 0;
      do begin
        @(posedge clock_i);
        i++;
      end while (done !== 1'b1 && i < 1000);
      if (i >= 1000) begin
        fail_count++;
        end_sim();
      end
    end
  endtask
  // Reads the snapshot once the update after a cycle end has landed.
  task automatic snap(input logic early);
    wait_done(1);
    if (early) begin
      xfer(1'b0, ADDR_BUS, 32'h0);
      check(rd, v[0]);
    end
    repeat (45) @(posedge clock_i);
    foreach (v[k]) begin
      xfer(1'b0, AD[k], 32'h0);
      v[k] = rd;
    end
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    xfer(1'b0, ADDR_CONTROL, 32'h0);
    check(rd, {16'h0, CTL_RESET});
    xfer(1'b0, ADDR_ACTIVE, 32'h0);
    check(rd, {16'h0, CTL_RESET});
    xfer(1'b0, 8'h40, 32'h0);
    check({31'h0, err}, 32'h1);
    xfer(1'b1, ADDR_ACTIVE, 32'h30);
    check({31'h0, err}, 32'h1);
    $display("reset test done");
  endtask
  task automatic t_cmds();
    logic [1:0]  cl [3];
    logic [31:0] c1;
    cl = '{CMD_REFRESH, CMD_REFRESH_G, CMD_REFRESH_V};
    foreach (cl[k]) begin
      wait_done(1);
      xfer(1'b1, ADDR_COMMAND, {30'h0, cl[k]});
      snap(1'b0);
      c1 = v[3];
      xfer(1'b1, ADDR_COMMAND, {30'h0, cl[k]});
      snap(1'b1);
      check(v[3], (cl[k] == CMD_REFRESH_V) ? c1 + 32'h1 : 32'h1);
      check(v[2], v[0] * v[1]);
      check(v[1] - v[0], 32'h100);
      c1 = v[0];
      wait_done(2);
      xfer(1'b0, ADDR_BUS, 32'h0);
      check(rd, c1);
    end
    $display("command test done");
  endtask
  task automatic t_auto();
    logic [31:0] b1, c1;
    xfer(1'b1, ADDR_CONTROL, 32'h10);
    wait_done(1);
    xfer(1'b1, ADDR_COMMAND, {30'h0, CMD_REFRESH});
    wait_done(2);
    xfer(1'b0, ADDR_ACTIVE, 32'h0);
    check(rd, 32'h10);
    snap(1'b0);
    b1 = v[0];
    c1 = v[3];
    xfer(1'b1, ADDR_COMMAND, {30'h0, CMD_REFRESH});
    snap(1'b0);
    check(v[0], b1 + 32'h1);
    check(v[3], c1 + 32'h1);
    b1 = v[0];
    xfer(1'b1, ADDR_CONTROL, 32'h110);
    snap(1'b0);
    check(v[0], b1);
    xfer(1'b0, ADDR_ACTIVE, 32'h0);
    check(rd, 32'h10);
    xfer(1'b1, ADDR_CONTROL, 32'h0);
    wait_done(1);
    xfer(1'b1, ADDR_COMMAND, {30'h0, CMD_REFRESH});
    wait_done(2);
    xfer(1'b0, ADDR_ACTIVE, 32'h0);
    check(rd, 32'h0);
    $display("auto test done");
  endtask
  task automatic t_slow();
    int i;
    xfer(1'b1, ADDR_CONTROL, 32'h300);
    wait_done(1);
    xfer(1'b1, ADDR_COMMAND, {30'h0, CMD_REFRESH});
    wait_done(2);
    xfer(1'b0, ADDR_ACTIVE, 32'h0);
    check(rd, 32'h300);
    pin0 <= 1'b1;
    wait_done(1);
    pin0 <= 1'b0;
    i = 0;
    do begin
      @(posedge clock_i);
      i++;
    end while (done !== 1'b1 && i < 60000);
    check(i, 32'(409600 / RATE_SLOW_SPS));
    $display("slow pin test done");
  endtask
  initial begin
    req = '0;
    pin0 = 1'b0;
    arst_n_i = 1'b0;
    fail_count = 0;
    n_checks = 0;
    repeat (12) @(posedge clock_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    t_reset();
    t_cmds();
    t_auto();
    t_slow();
    end_sim();
  end
endmodule
